// File: bench/tb_top.sv
// self-checking bench for the link tuning and 10/100 mode register bank
`timescale 1ns/10ps
module tb_top;
  logic                 clk_sys_i;
  logic                 rst_b_i;
  logic                 soft_rst_i;
  logic [4:0]           addr_i;
  logic [15:0]          wdata_i;
  logic                 wr_i;
  logic                 rd_i;
  logic [15:0]          rdata_o;
  logic                 energy_i;
  logic                 adv_np_i;
  logic [1:0]           manual_pair_i;
  logic [1:0]           auto_pair_i;
  logic                 flag_clr_i;
  logic                 energy_chg_o;
  logic                 logic_rst_o;
  link_mode_pkg::ctrl_t ctrl_o;
  logic [1:0]           pair_map_o;
  int                   n_fail;
  int                   n_checks;

  link_mode_regs i_dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .soft_rst_i(soft_rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .energy_i(energy_i), .adv_np_i(adv_np_i),
    .manual_pair_i(manual_pair_i), .auto_pair_i(auto_pair_i), .flag_clr_i(flag_clr_i),
    .energy_chg_o(energy_chg_o), .logic_rst_o(logic_rst_o), .ctrl_o(ctrl_o), .pair_map_o(pair_map_o));

  // 200 MHz core clock
  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  task automatic close_out();
    if (n_fail == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one-cycle write strobe, effect visible once the edge has landed
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    addr_i <= a; wdata_i <= d; wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
    #1;
  endtask : wr

  // read data stand from the cycle after the strobe until the next read
  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    @(posedge clk_sys_i);
    addr_i <= a; rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, exp);
  endtask : rd

  // bounded wait for the energy change flag
  task automatic wait_flag();
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys_i);
      #1;
      if (energy_chg_o === 1'b1) return;
    end
    n_fail++;
    close_out();
  endtask : wait_flag

  initial begin
    n_fail = 0; n_checks = 0;
    rst_b_i = 1'b0; soft_rst_i = 1'b0; addr_i = 5'h00; wdata_i = 16'h0000; wr_i = 1'b0; rd_i = 1'b0;
    energy_i = 1'b1; adv_np_i = 1'b0; manual_pair_i = 2'h1; auto_pair_i = 2'h2; flag_clr_i = 1'b0;
    repeat (12) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    // defaults after hardware reset, energy bit set
    rd(5'h10, 16'h0020);
    rd(5'h11, 16'h0042);
    chk({13'h0, ctrl_o.spd_attempts}, 16'h0007);
    chk({15'h0, energy_chg_o}, 16'h0000);
    // logic reset stays up, bit 0 never reads back
    wr(5'h10, 16'h0009);
    repeat (5) @(posedge clk_sys_i);
    #1;
    chk({14'h0, logic_rst_o, ctrl_o.brk_enable}, 16'h0003);
    rd(5'h10, 16'h0008);
    // writable bits only, reserved bits read zero
    wr(5'h10, 16'hffff);
    chk({15'h0, ctrl_o.pwr_opt_enable}, 16'h0000);
    rd(5'h10, 16'h033c);
    wr(5'h11, 16'hffff);
    rd(5'h11, 16'hf0f3);
    chk({9'h0, ctrl_o.energy_detect_short_sel, ctrl_o.ten_mbps_test_mode, ctrl_o.energy_power_down_enable,
         ctrl_o.ed_pd_with_nlp, ctrl_o.spd_opt_enable, ctrl_o.np_enable, ctrl_o.semi_x_enable},
        16'h007f);
    // every attempt code and threshold code, logic reset kept set
    for (int i = 0; i < 4; i++) begin
      wr(5'h10, {6'h0, i[1:0], 2'h0, i[1:0], 4'h1});
      chk({13'h0, ctrl_o.spd_attempts}, (i == 0) ? 16'h7 : (i == 1) ? 16'h5 : (i == 2) ? 16'h4 : 16'h3);
      chk({14'h0, ctrl_o.brk_threshold}, {14'h0, i[1:0]});
    end
    // manual mapping only while auto crossover is off
    wr(5'h11, 16'h0020);
    chk({13'h0, ctrl_o.auto_mdix_enable, pair_map_o}, 16'h0001);
    chk({14'h0, ctrl_o.pair_crossed}, 16'h0001);
    wr(5'h11, 16'h0010);
    chk({13'h0, ctrl_o.auto_np_enable, pair_map_o}, 16'h0002);
    chk({15'h0, ctrl_o.send_base_only}, 16'h0001);
    @(posedge clk_sys_i);
    adv_np_i <= 1'b1;
    #1;
    chk({15'h0, ctrl_o.send_base_only}, 16'h0000);
    // unmapped index reads zero, writes dropped
    wr(5'h12, 16'hffff);
    rd(5'h12, 16'h0000);
    rd(5'h11, 16'h0012);
    // flag raised by an energy change, cleared by write-one
    @(posedge clk_sys_i);
    energy_i <= 1'b0;
    wait_flag();
    @(posedge clk_sys_i);
    energy_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    flag_clr_i <= 1'b1;
    @(posedge clk_sys_i);
    flag_clr_i <= 1'b0;
    #1;
    chk({15'h0, energy_chg_o}, 16'h0000);
    // software reset: defaults back, energy bit cleared, flag raised
    @(posedge clk_sys_i);
    soft_rst_i <= 1'b1;
    @(posedge clk_sys_i);
    soft_rst_i <= 1'b0;
    addr_i <= 5'h11; rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, 16'h0040);
    chk({15'h0, energy_chg_o}, 16'h0001);
    chk({15'h0, logic_rst_o}, 16'h0001);
    rd(5'h10, 16'h0020);
    // logic reset drops only when software writes zero
    wr(5'h10, 16'h0000);
    chk({15'h0, logic_rst_o}, 16'h0000);
    close_out();
  end
endmodule : tb_top

// File: hw/attempt_decode.sv
// decode of the speed optimize attempt code
`timescale 1ns/10ps
module attempt_decode (
  input  wire logic [1:0] code_i,     // attempt code field
  output logic      [2:0] attempts_o  // attempt count
);
  // table is fixed, no arithmetic shortcut fits 7,5,4,3
  always_comb begin
    unique case (code_i)
      2'h0: attempts_o = 3'h7;
      2'h1: attempts_o = 3'h5;
      2'h2: attempts_o = 3'h4;
      2'h3: attempts_o = 3'h3;
    endcase
  end
endmodule : attempt_decode

// File: hw/link_mode_pkg.sv
// constants and types for the link tuning and 10/100 mode register bank
package link_mode_pkg;
  localparam logic [4:0]  LINK_TUNING_ADDR = 5'h10;
  localparam logic [4:0]  MODE_CTRL_ADDR   = 5'h11;
  localparam int          SPD_ATT_LSB      = 8;
  localparam int          BRK_THR_LSB      = 4;
  localparam int          BRK_EN_BIT       = 3;
  localparam int          PWR_OPT_DIS_BIT  = 2;
  localparam int          LOGIC_RST_BIT    = 0;
  localparam int          ED_SHORT_BIT     = 15;
  localparam int          FAST_TEST_BIT    = 14;
  localparam int          ED_PD_EN_BIT     = 13;
  localparam int          ED_PD_NLP_BIT    = 12;
  localparam int          SPD_OPT_EN_BIT   = 7;
  localparam int          NP_EN_BIT        = 6;
  localparam int          MDIX_DIS_BIT     = 5;
  localparam int          AUTO_NP_DIS_BIT  = 4;
  localparam int          ENERGY_BIT       = 1;
  localparam int          SEMI_X_BIT       = 0;
  localparam logic [1:0]  SPD_ATT_RST      = 2'h0;
  localparam logic [1:0]  BRK_THR_RST      = 2'h2;
  localparam logic [15:0] LINK_TUNING_WMASK = 16'h033c;
  localparam logic [15:0] MODE_CTRL_WMASK   = 16'hf0f1;
  localparam logic [15:0] MODE_CTRL_RST     = 16'h0040;

  // control fields handed to the negotiation, crossover and power logic
  typedef struct packed {
    logic [2:0] spd_attempts;     // attempts before speed drop
    logic [1:0] brk_threshold;    // 0:1e-8 .. 3:1e-11
    logic       brk_enable;
    logic       pwr_opt_enable;
    logic       energy_detect_short_sel;
    logic       ten_mbps_test_mode;
    logic       energy_power_down_enable;
    logic       ed_pd_with_nlp;
    logic       spd_opt_enable;
    logic       np_enable;
    logic       auto_mdix_enable;
    logic [1:0] pair_crossed;     // [1]=ch0:1, [0]=ch2:3
    logic       auto_np_enable;
    logic       send_base_only;
    logic       semi_x_enable;
  } ctrl_t;
endpackage : link_mode_pkg

// File: hw/link_mode_regs.sv
// link tuning and 10/100 mode control/status registers
`timescale 1ns/10ps
module link_mode_regs (
  input  wire logic                 clk_sys_i,      // 200 MHz core clock
  input  wire logic                 rst_b_i,        // hardware reset, async, low
  input  wire logic                 soft_rst_i,     // software reset pulse
  input  wire logic [4:0]           addr_i,         // register index
  input  wire logic [15:0]          wdata_i,        // write data
  input  wire logic                 wr_i,           // write strobe
  input  wire logic                 rd_i,           // read strobe
  output logic      [15:0]          rdata_o,        // read data, cycle after rd_i
  input  wire logic                 energy_i,       // energy seen on the line
  input  wire logic                 adv_np_i,       // advertised next page bit
  input  wire logic [1:0]           manual_pair_i,  // manual pair selection
  input  wire logic [1:0]           auto_pair_i,    // crossover engine mapping
  input  wire logic                 flag_clr_i,     // energy change flag write-one
  output logic                      energy_chg_o,   // energy change flag
  output logic                      logic_rst_o,    // synchronous logic reset
  output link_mode_pkg::ctrl_t      ctrl_o,         // decoded control fields
  output logic      [1:0]           pair_map_o      // pair mapping in use
);
  logic [15:0] tune_q;
  logic [15:0] mode_q;
  logic        logic_rst_q;
  logic        energy_q;
  logic        chg_q;
  logic        wr_tune;
  logic        wr_mode;
  logic [2:0]  attempts;

  assign wr_tune = wr_i && addr_i == link_mode_pkg::LINK_TUNING_ADDR;
  assign wr_mode = wr_i && addr_i == link_mode_pkg::MODE_CTRL_ADDR;

  // link tuning fields; software reset returns them to defaults
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tune_q <= {6'h00, link_mode_pkg::SPD_ATT_RST, 2'h0, link_mode_pkg::BRK_THR_RST, 4'h0};
    end else if (soft_rst_i) begin
      tune_q <= {6'h00, link_mode_pkg::SPD_ATT_RST, 2'h0, link_mode_pkg::BRK_THR_RST, 4'h0};
    end else if (wr_tune) begin
      tune_q <= wdata_i & link_mode_pkg::LINK_TUNING_WMASK;
    end
  end

  // logic reset stays asserted until software writes zero
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      logic_rst_q <= 1'b0;
    end else if (wr_tune) begin
      logic_rst_q <= wdata_i[link_mode_pkg::LOGIC_RST_BIT];
    end
  end
  assign logic_rst_o = logic_rst_q;

  // 10/100 mode fields; register sets are outside the logic reset
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mode_q <= link_mode_pkg::MODE_CTRL_RST;
    end else if (soft_rst_i) begin
      mode_q <= link_mode_pkg::MODE_CTRL_RST;
    end else if (wr_mode) begin
      mode_q <= wdata_i & link_mode_pkg::MODE_CTRL_WMASK;
    end
  end

  // energy indication: set at hardware reset, cleared by software reset
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      energy_q <= 1'b1;
    end else if (soft_rst_i) begin
      energy_q <= 1'b0;
    end else begin
      energy_q <= energy_i;
    end
  end

  // change flag: set wins over the write-one clear
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      chg_q <= 1'b0;
    end else if ((soft_rst_i && energy_q) || (!soft_rst_i && energy_q != energy_i)) begin
      chg_q <= 1'b1;
    end else if (flag_clr_i) begin
      chg_q <= 1'b0;
    end
  end
  assign energy_chg_o = chg_q;

  // read path, reserved bits and logic reset bit read as zero
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o <= 16'h0000;
    end else if (rd_i) begin
      unique case (addr_i)
        link_mode_pkg::LINK_TUNING_ADDR: rdata_o <= tune_q;
        link_mode_pkg::MODE_CTRL_ADDR:   rdata_o <= mode_q | {14'h0000, energy_q, 1'b0};
        default:                         rdata_o <= 16'h0000;
      endcase
    end
  end

  attempt_decode u_attempt_decode (
    .code_i     (tune_q[link_mode_pkg::SPD_ATT_LSB +: 2]),
    .attempts_o (attempts)
  );

  pair_select u_pair_select (
    .auto_en_i  (!mode_q[link_mode_pkg::MDIX_DIS_BIT]),
    .auto_map_i (auto_pair_i),
    .manual_i   (manual_pair_i),
    .map_o      (pair_map_o)
  );

  // control fields for the engines steered by these bits
  always_comb begin
    ctrl_o.spd_attempts             = attempts;
    ctrl_o.brk_threshold            = tune_q[link_mode_pkg::BRK_THR_LSB +: 2];
    ctrl_o.brk_enable               = tune_q[link_mode_pkg::BRK_EN_BIT];
    ctrl_o.pwr_opt_enable           = !tune_q[link_mode_pkg::PWR_OPT_DIS_BIT];
    ctrl_o.energy_detect_short_sel  = mode_q[link_mode_pkg::ED_SHORT_BIT];
    ctrl_o.ten_mbps_test_mode       = mode_q[link_mode_pkg::FAST_TEST_BIT];
    ctrl_o.energy_power_down_enable = mode_q[link_mode_pkg::ED_PD_EN_BIT];
    ctrl_o.ed_pd_with_nlp           = mode_q[link_mode_pkg::ED_PD_NLP_BIT];
    ctrl_o.spd_opt_enable           = mode_q[link_mode_pkg::SPD_OPT_EN_BIT];
    ctrl_o.np_enable                = mode_q[link_mode_pkg::NP_EN_BIT];
    ctrl_o.auto_mdix_enable         = !mode_q[link_mode_pkg::MDIX_DIS_BIT];
    ctrl_o.pair_crossed             = pair_map_o;
    ctrl_o.auto_np_enable           = !mode_q[link_mode_pkg::AUTO_NP_DIS_BIT];
    ctrl_o.send_base_only           = mode_q[link_mode_pkg::AUTO_NP_DIS_BIT] && !adv_np_i;
    ctrl_o.semi_x_enable            = mode_q[link_mode_pkg::SEMI_X_BIT];
  end

  // checks
  energy_clr_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    soft_rst_i |=> !energy_q) else $error("energy not cleared by soft reset");
  chg_set_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (soft_rst_i && energy_q) |=> chg_q) else $error("change flag not set");
  logic_rst_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (logic_rst_o && !wr_tune) |=> logic_rst_o) else $error("logic reset cleared itself");
  logic_rst_set_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (wr_tune && wdata_i[0]) |=> logic_rst_o) else $error("logic reset not issued");
  base_only_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    ctrl_o.send_base_only |-> !ctrl_o.auto_np_enable && !adv_np_i) else $error("base page wrong");
  manual_map_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    !ctrl_o.auto_mdix_enable |-> pair_map_o == manual_pair_i) else $error("manual map ignored");
  tune_wr_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (wr_tune && !soft_rst_i) |=> ctrl_o.brk_enable == $past(wdata_i[3])) else $error("break enable");
  attempts_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (tune_q[9:8] == 2'h0) |-> ctrl_o.spd_attempts == 3'h7) else $error("attempt decode");
  np_reset_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    soft_rst_i |=> ctrl_o.np_enable) else $error("next page default");
  // energy bit follows the detector one cycle late outside software reset
  energy_track_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    !soft_rst_i |=> energy_q == $past(energy_i)) else $error("energy bit does not follow the line");
  // clear only lands when no set event shares the cycle
  chg_clear_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (flag_clr_i && !soft_rst_i && energy_q == energy_i) |=> !chg_q) else $error("change flag not cleared");
  mode_wr_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (wr_mode && !soft_rst_i) |=> mode_q == ($past(wdata_i) & link_mode_pkg::MODE_CTRL_WMASK))
    else $error("mode write lost");
  tune_dflt_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    soft_rst_i |=> tune_q == {6'h00, link_mode_pkg::SPD_ATT_RST, 2'h0, link_mode_pkg::BRK_THR_RST, 4'h0})
    else $error("tuning defaults not restored");
  // software reset leaves the logic reset bit alone
  logic_rst_soft_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (soft_rst_i && !wr_tune) |=> logic_rst_o == $past(logic_rst_o)) else $error("logic reset hit by soft reset");
  rd_energy_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (rd_i && addr_i == link_mode_pkg::MODE_CTRL_ADDR) |=> rdata_o[link_mode_pkg::ENERGY_BIT] == $past(energy_q))
    else $error("energy bit read wrong");
  rd_logic_reset_bit_zero_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (rd_i && addr_i == link_mode_pkg::LINK_TUNING_ADDR) |=> !rdata_o[link_mode_pkg::LOGIC_RST_BIT])
    else $error("logic reset bit read back");
endmodule : link_mode_regs

// File: hw/pair_select.sv
// manual or automatic crossover pair mapping
`timescale 1ns/10ps
module pair_select (
  input  wire logic       auto_en_i,   // automatic crossover enabled
  input  wire logic [1:0] auto_map_i,  // mapping resolved by crossover engine
  input  wire logic [1:0] manual_i,    // manual selection, 1 = crossed
  output logic      [1:0] map_o        // mapping in use
);
  // manual bits ignored while automatic resolution runs
  assign map_o = auto_en_i ? auto_map_i : manual_i;
endmodule : pair_select
